// ---- dv/pulse_event_counter_props.sv ----
// Port-level assertions for the pulse event counter
`timescale 1ns/1ps
`default_nettype none
module pulse_event_counter_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [pulse_event_counter_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pulse_event_counter_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pulse_event_counter_pkg::DATA_W-1:0] reg_rdata,
	// Terminals
	input wire logic input_terminal_one,
	input wire logic input_terminal_two,
	input wire logic input_terminal_three,
	input wire logic input_terminal_four,
	input wire logic fast_pulse_terminal,
	// Outputs
	input wire logic transistor_output,
	input wire logic relay_output_one,
	input wire logic relay_output_two,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic quiet;
	// Eight quiet cycles flush the terminal filter, so no output and not irq may move after
	assign quiet = !reg_wr && !input_terminal_one && !input_terminal_two &&
		!input_terminal_three && !input_terminal_four && !fast_pulse_terminal;
	sequence s_quiet;
		quiet [*8];
	endsequence
	sequence s_mask_off;
		reg_wr && reg_addr == 4'hD && reg_wdata == 16'h0000 ##1 !(reg_wr && reg_addr == 4'hD);
	endsequence
	property p_idle_rdata;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr > 4'hD |=> reg_rdata == 16'h0000;
	endproperty
	property p_type_width;
		reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:1] == 15'h0000;
	endproperty
	property p_func_width;
		reg_rd && reg_addr inside {[4'h1:4'h5]} |=> reg_rdata[15:7] == 9'h000;
	endproperty
	property p_osel_width;
		reg_rd && reg_addr inside {[4'h6:4'h8]} |=> reg_rdata[15:6] == 10'h000;
	endproperty
	property p_quiet_stable;
		s_quiet |=> $stable({transistor_output, relay_output_one, relay_output_two, irq});
	endproperty
	property p_mask_off;
		s_mask_off |=> !irq;
	endproperty
	property p_release;
		$fell(rst) |-> !transistor_output && !relay_output_one && !relay_output_two && !irq;
	endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("read data not idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_type_width: assert property (p_type_width) else $error("type field too wide");
	a_func_width: assert property (p_func_width) else $error("function too wide");
	a_osel_width: assert property (p_osel_width) else $error("selection too wide");
	a_quiet_stable: assert property (p_quiet_stable) else $error("outputs moved");
	a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
	a_release: assert property (p_release) else $error("outputs high after reset");
endmodule
bind pulse_event_counter pulse_event_counter_props pulse_event_counter_props_inst (.*);
`default_nettype wire

// ---- dv/pulse_sensor_model.sv ----
// Photoelectric switch model that fires one count pulse per request
`timescale 1ns/1ps
`default_nettype none
module pulse_sensor_model (
	// Clock
	input wire logic clk_sys,
	// Request from the bench
	input wire logic go,
	input wire logic [4:0] sel,
	input wire logic [4:0] hold,
	input wire logic [3:0] gap,
	// Terminal levels and status
	output logic [4:0] pins,
	output logic busy
);
	logic [4:0] step_ff = 5'h00;
	logic [4:0] sel_ff = 5'h00;
	logic high_ff = 1'b0;
	logic busy_ff = 1'b0;
	// Gap sets both high and low time, so prompt and slow pulses both occur
	always @(posedge clk_sys) begin
		if (go && !busy_ff) begin
			busy_ff <= 1'b1;
			high_ff <= 1'b1;
			step_ff <= 5'h00;
			sel_ff <= sel;
		end else if (busy_ff) begin
			step_ff <= step_ff + 5'h01;
			if (step_ff == {1'b0, gap})
				high_ff <= 1'b0;
			if (step_ff == {gap, 1'b0})
				busy_ff <= 1'b0;
		end
	end
	assign pins = hold | ({5{high_ff}} & sel_ff);
	assign busy = busy_ff;
endmodule
`default_nettype wire

// ---- dv/test_pulse_event_counter.sv ----
// Self-checking bench for the pulse event counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_pulse_event_counter;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [4:0] pins;
	logic [4:0] sel = 5'h00;
	logic [4:0] hold = 5'h00;
	logic [3:0] gap = 4'h4;
	logic go = 1'b0;
	logic busy, t_out, r_one, r_two, irq;
	logic [5:0] r2sel;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	int cnt, setv, desig, t;
	logic [15:0] rv [12] = '{0, 1, 4, 7, 0, 0, 0, 1, 5, 0, 0, 0};
	always #2 clk_sys = ~clk_sys;
	pulse_event_counter pulse_event_counter_inst (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .input_terminal_one(pins[0]), .input_terminal_two(pins[1]),
		.input_terminal_three(pins[2]), .input_terminal_four(pins[3]),
		.fast_pulse_terminal(pins[4]), .transistor_output(t_out), .relay_output_one(r_one),
		.relay_output_two(r_two), .irq(irq));
	pulse_sensor_model pulse_sensor_model_inst (.clk_sys(clk_sys), .go(go), .sel(sel),
		.hold(hold), .gap(gap), .pins(pins), .busy(busy));
	// Output level expected for a selection code at a given count
	function automatic logic out_exp(logic [5:0] s, int c, int sv, int d);
		return (s == 6'h12 && c == sv) || (s == 6'h13 && c == d);
	endfunction
	function automatic int nxt(int c, int s);
		if (c >= s)
			return (s == 0) ? 0 : 1;
		return c + 1;
	endfunction
	task automatic results;
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(reg_rdata, exp)
	endtask
	// Filter plus count update need about six edges after the pulse ends
	task automatic pulse(input logic [4:0] s);
		int n;
		@(posedge clk_sys);
		sel <= s;
		gap <= 4'(4 + $urandom % 8);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (busy && n < 40);
		repeat (6) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			$display("MISMATCH t=%0t timeout", $time);
			results();
		end
	end
	initial begin
		void'($urandom(32'h1cff));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			chk_rd(4'(i), rv[i]);
		chk_rd(4'hE, 16'h0000);
		setv = 3 + $urandom % 6;
		desig = 1 + $urandom % setv;
		wr(4'h9, 16'(setv));
		wr(4'hA, 16'hFFFF);
		chk_rd(4'hA, 16'(setv));
		wr(4'hA, 16'(desig));
		wr(4'h1, 16'h001F);
		wr(4'h2, 16'h001C);
		wr(4'h3, 16'h001F);
		wr(4'h4, 16'h001F);
		wr(4'h6, 16'h0012);
		wr(4'h7, 16'h0013);
		// Relay two takes disabled, set-reached or designated-reached at random
		t = $urandom % 3;
		r2sel = (t == 0) ? 6'h00 : 6'(6'h11 + t);
		wr(4'h8, 16'(r2sel));
		wr(4'hC, 16'h0007);
		wr(4'hD, 16'h0001);
		cnt = 0;
		// Runs past the set value so the restart is crossed
		for (int k = 0; k < setv + 3; k++) begin
			t = $urandom % 3;
			pulse(5'(1 << (t == 0 ? 0 : t + 1)));
			cnt = nxt(cnt, setv);
			chk_rd(4'hB, 16'(cnt));
			`CHK(t_out, cnt == setv)
			`CHK(r_one, cnt == desig)
			`CHK(r_two, out_exp(r2sel, cnt, setv, desig))
		end
		`CHK(irq, 1'b1)
		wr(4'hD, 16'h0000);
		chk_rd(4'hC, 16'h0003);
		`CHK(irq, 1'b0)
		wr(4'hD, 16'h0004);
		@(posedge clk_sys);
		hold <= 5'h02;
		repeat (10) @(posedge clk_sys);
		cnt = 0;
		chk_rd(4'hB, 16'h0000);
		`CHK(irq, 1'b1)
		hold <= 5'h00;
		repeat (10) @(posedge clk_sys);
		wr(4'hC, 16'h0007);
		chk_rd(4'hC, 16'h0000);
		`CHK(irq, 1'b0)
		wr(4'h5, 16'h001F);
		pulse(5'h10);
		chk_rd(4'hB, 16'h0000);
		wr(4'h0, 16'h0001);
		wr(4'h5, 16'h001F);
		pulse(5'h10);
		chk_rd(4'hB, 16'h0001);
		wr(4'hB, 16'h1234);
		chk_rd(4'hB, 16'h0001);
		wr(4'hF, 16'hFFFF);
		chk_rd(4'hF, 16'h0000);
		results();
	end
endmodule
`default_nettype wire

// ---- verilog/pulse_event_counter.sv ----
// Pulse event counter with terminal function selection and count-reached outputs
`timescale 1ns/1ps
`default_nettype none
module pulse_event_counter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [pulse_event_counter_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pulse_event_counter_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pulse_event_counter_pkg::DATA_W-1:0] reg_rdata,
	// Input terminals
	input wire logic input_terminal_one,
	input wire logic input_terminal_two,
	input wire logic input_terminal_three,
	input wire logic input_terminal_four,
	input wire logic fast_pulse_terminal,
	// Outputs to loads
	output logic transistor_output,
	output logic relay_output_one,
	output logic relay_output_two,
	// Interrupt
	output logic irq
);
	localparam int NT = pulse_event_counter_pkg::NUM_TERM;
	localparam int FW = pulse_event_counter_pkg::FUNC_W;
	localparam int OW = pulse_event_counter_pkg::OSEL_W;
	localparam int CW = pulse_event_counter_pkg::CNT_W;
	localparam int DW = pulse_event_counter_pkg::DATA_W;
	localparam int NE = pulse_event_counter_pkg::NUM_EVT;

	typedef enum logic [1:0] {
		CNT_IDLE = 2'b00,
		CNT_RUN = 2'b01,
		CNT_HELD = 2'b10
	} cnt_state_e;

	logic [NT-1:0] pin_level;
	logic [NT-1:0] level_prev_ff;
	logic [NT-1:0] nxt_level_prev;

	logic fast_type_ff;
	logic nxt_fast_type;
	logic [FW-1:0] func_ff [NT];
	logic [FW-1:0] nxt_func [NT];
	logic [OW-1:0] trans_sel_ff;
	logic [OW-1:0] nxt_trans_sel;
	logic [OW-1:0] relay_one_sel_ff;
	logic [OW-1:0] nxt_relay_one_sel;
	logic [OW-1:0] relay_two_sel_ff;
	logic [OW-1:0] nxt_relay_two_sel;
	logic [CW-1:0] set_value_ff;
	logic [CW-1:0] nxt_set_value;
	logic [CW-1:0] desig_value_ff;
	logic [CW-1:0] nxt_desig_value;

	cnt_state_e state_ff;
	cnt_state_e nxt_state;
	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	logic trigger_pulse;
	logic reset_active;

	logic [NE-1:0] status_ff;
	logic [NE-1:0] nxt_status;
	logic [NE-1:0] mask_ff;
	logic [NE-1:0] nxt_mask;
	logic [NE-1:0] event_hit;
	logic irq_ff;
	logic nxt_irq;

	logic trans_ff;
	logic nxt_trans;
	logic relay_one_ff;
	logic nxt_relay_one;
	logic relay_two_ff;
	logic nxt_relay_two;
	logic [DW-1:0] rdata_ff;
	logic [DW-1:0] nxt_rdata;

	function automatic logic write_to(input logic [pulse_event_counter_pkg::ADDR_W-1:0] idx);
		write_to = reg_wr && (reg_addr == idx);
	endfunction

	function automatic logic output_on(input logic [OW-1:0] sel, input logic [CW-1:0] cnt);
		output_on = ((sel == pulse_event_counter_pkg::OSEL_SET_REACHED) && (cnt == set_value_ff)) ||
			((sel == pulse_event_counter_pkg::OSEL_DESIG_REACHED) && (cnt == desig_value_ff));
	endfunction

	// Terminal may carry a counter function only if it is a digital input
	function automatic logic term_is(input int t, input logic [FW-1:0] code);
		term_is = (func_ff[t] == code) &&
			((t != pulse_event_counter_pkg::FAST_IDX) ||
			(fast_type_ff == pulse_event_counter_pkg::FAST_TYPE_DIGITAL));
	endfunction

	terminal_sync #(
		.WIDTH(NT)
	) terminal_sync_inst (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_raw({fast_pulse_terminal, input_terminal_four, input_terminal_three,
			input_terminal_two, input_terminal_one}),
		.pin_level(pin_level)
	);

	// Configuration registers
	always_comb begin
		nxt_fast_type = fast_type_ff;
		nxt_trans_sel = trans_sel_ff;
		nxt_relay_one_sel = relay_one_sel_ff;
		nxt_relay_two_sel = relay_two_sel_ff;
		nxt_set_value = set_value_ff;
		nxt_desig_value = desig_value_ff;
		nxt_mask = mask_ff;
		for (int t = 0; t < NT; t++) begin
			nxt_func[t] = func_ff[t];
		end
		if (write_to(pulse_event_counter_pkg::REG_FAST_TYPE)) begin
			nxt_fast_type = reg_wdata[0];
		end
		for (int t = 0; t < NT; t++) begin
			if (write_to(pulse_event_counter_pkg::REG_IN_ONE_FUNC + 4'(t))) begin
				nxt_func[t] = reg_wdata[FW-1:0];
			end
		end
		if (write_to(pulse_event_counter_pkg::REG_TRANS_SEL)) begin
			nxt_trans_sel = reg_wdata[OW-1:0];
		end
		if (write_to(pulse_event_counter_pkg::REG_RELAY_ONE_SEL)) begin
			nxt_relay_one_sel = reg_wdata[OW-1:0];
		end
		if (write_to(pulse_event_counter_pkg::REG_RELAY_TWO_SEL)) begin
			nxt_relay_two_sel = reg_wdata[OW-1:0];
		end
		if (write_to(pulse_event_counter_pkg::REG_SET_VALUE)) begin
			nxt_set_value = reg_wdata;
			// Lowering the set value drags the designated value with it
			if (reg_wdata < desig_value_ff) begin
				nxt_desig_value = reg_wdata;
			end
		end
		if (write_to(pulse_event_counter_pkg::REG_DESIG_VALUE)) begin
			nxt_desig_value = (reg_wdata > set_value_ff) ? set_value_ff : reg_wdata;
		end
		if (write_to(pulse_event_counter_pkg::REG_IRQ_MASK)) begin
			nxt_mask = reg_wdata[NE-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fast_type_ff <= pulse_event_counter_pkg::RST_FAST_TYPE;
			func_ff[0] <= pulse_event_counter_pkg::RST_IN_ONE_FUNC;
			func_ff[1] <= pulse_event_counter_pkg::RST_IN_TWO_FUNC;
			func_ff[2] <= pulse_event_counter_pkg::RST_IN_THREE_FUNC;
			func_ff[3] <= pulse_event_counter_pkg::RST_IN_FOUR_FUNC;
			func_ff[4] <= pulse_event_counter_pkg::RST_FAST_FUNC;
			trans_sel_ff <= pulse_event_counter_pkg::RST_TRANS_SEL;
			relay_one_sel_ff <= pulse_event_counter_pkg::RST_RELAY_ONE_SEL;
			relay_two_sel_ff <= pulse_event_counter_pkg::RST_RELAY_TWO_SEL;
			set_value_ff <= pulse_event_counter_pkg::RST_COUNT;
			desig_value_ff <= pulse_event_counter_pkg::RST_COUNT;
			mask_ff <= '0;
		end else begin
			fast_type_ff <= nxt_fast_type;
			for (int t = 0; t < NT; t++) begin
				func_ff[t] <= nxt_func[t];
			end
			trans_sel_ff <= nxt_trans_sel;
			relay_one_sel_ff <= nxt_relay_one_sel;
			relay_two_sel_ff <= nxt_relay_two_sel;
			set_value_ff <= nxt_set_value;
			desig_value_ff <= nxt_desig_value;
			mask_ff <= nxt_mask;
		end
	end

	// Counter
	always_comb begin
		nxt_level_prev = pin_level;
		trigger_pulse = 1'b0;
		reset_active = 1'b0;
		for (int t = 0; t < NT; t++) begin
			// Several trigger terminals on one cycle count as one pulse
			if (term_is(t, pulse_event_counter_pkg::FUNC_COUNT_TRIGGER) &&
				pin_level[t] && !level_prev_ff[t]) begin
				trigger_pulse = 1'b1;
			end
			if (term_is(t, pulse_event_counter_pkg::FUNC_COUNT_RESET) && pin_level[t]) begin
				reset_active = 1'b1;
			end
		end
		nxt_state = state_ff;
		nxt_count = count_ff;
		case (state_ff)
			CNT_IDLE: begin
				if (!reset_active) begin
					nxt_state = CNT_RUN;
				end
			end
			CNT_RUN: begin
				if (reset_active) begin
					nxt_count = pulse_event_counter_pkg::RST_COUNT;
					nxt_state = CNT_HELD;
				end else if (trigger_pulse) begin
					if (count_ff >= set_value_ff) begin
						// Reached: this pulse becomes the first of a new round
						nxt_count = (set_value_ff == pulse_event_counter_pkg::RST_COUNT) ?
							pulse_event_counter_pkg::RST_COUNT :
							pulse_event_counter_pkg::CNT_ONE;
					end else begin
						nxt_count = count_ff + pulse_event_counter_pkg::CNT_ONE;
					end
				end
			end
			CNT_HELD: begin
				nxt_count = pulse_event_counter_pkg::RST_COUNT;
				if (!reset_active) begin
					nxt_state = CNT_RUN;
				end
			end
			default: begin
				nxt_state = CNT_IDLE;
				nxt_count = pulse_event_counter_pkg::RST_COUNT;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= CNT_IDLE;
			count_ff <= pulse_event_counter_pkg::RST_COUNT;
			level_prev_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			level_prev_ff <= nxt_level_prev;
		end
	end

	// Interrupt status, mask and line
	always_comb begin
		event_hit = '0;
		event_hit[pulse_event_counter_pkg::EVT_SET_REACHED] =
			(nxt_count == set_value_ff) && (count_ff != set_value_ff);
		event_hit[pulse_event_counter_pkg::EVT_DESIG_REACHED] =
			(nxt_count == desig_value_ff) && (count_ff != desig_value_ff);
		event_hit[pulse_event_counter_pkg::EVT_CLEARED] = reset_active && (state_ff == CNT_RUN);
		nxt_status = status_ff;
		if (write_to(pulse_event_counter_pkg::REG_IRQ_STATUS)) begin
			nxt_status = status_ff & ~reg_wdata[NE-1:0];
		end
		// A new event beats a clear in the same cycle
		nxt_status = nxt_status | event_hit;
		nxt_irq = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_ff <= nxt_irq;
		end
	end

	// Output drivers and read data
	always_comb begin
		nxt_trans = output_on(trans_sel_ff, count_ff);
		nxt_relay_one = output_on(relay_one_sel_ff, count_ff);
		nxt_relay_two = output_on(relay_two_sel_ff, count_ff);
		nxt_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				pulse_event_counter_pkg::REG_FAST_TYPE: nxt_rdata = DW'(fast_type_ff);
				pulse_event_counter_pkg::REG_IN_ONE_FUNC: nxt_rdata = DW'(func_ff[0]);
				pulse_event_counter_pkg::REG_IN_TWO_FUNC: nxt_rdata = DW'(func_ff[1]);
				pulse_event_counter_pkg::REG_IN_THREE_FUNC: nxt_rdata = DW'(func_ff[2]);
				pulse_event_counter_pkg::REG_IN_FOUR_FUNC: nxt_rdata = DW'(func_ff[3]);
				pulse_event_counter_pkg::REG_FAST_FUNC: nxt_rdata = DW'(func_ff[4]);
				pulse_event_counter_pkg::REG_TRANS_SEL: nxt_rdata = DW'(trans_sel_ff);
				pulse_event_counter_pkg::REG_RELAY_ONE_SEL: nxt_rdata = DW'(relay_one_sel_ff);
				pulse_event_counter_pkg::REG_RELAY_TWO_SEL: nxt_rdata = DW'(relay_two_sel_ff);
				pulse_event_counter_pkg::REG_SET_VALUE: nxt_rdata = set_value_ff;
				pulse_event_counter_pkg::REG_DESIG_VALUE: nxt_rdata = desig_value_ff;
				pulse_event_counter_pkg::REG_ACCUM: nxt_rdata = count_ff;
				pulse_event_counter_pkg::REG_IRQ_STATUS: nxt_rdata = DW'(status_ff);
				pulse_event_counter_pkg::REG_IRQ_MASK: nxt_rdata = DW'(mask_ff);
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trans_ff <= 1'b0;
			relay_one_ff <= 1'b0;
			relay_two_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			trans_ff <= nxt_trans;
			relay_one_ff <= nxt_relay_one;
			relay_two_ff <= nxt_relay_two;
			rdata_ff <= nxt_rdata;
		end
	end

	assign transistor_output = trans_ff;
	assign relay_output_one = relay_one_ff;
	assign relay_output_two = relay_two_ff;
	assign irq = irq_ff;
	assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- verilog/pulse_event_counter_pkg.sv ----
// Constants for the pulse event counter: register map, codes, reset values
`default_nettype none
package pulse_event_counter_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int FUNC_W = 7;
	localparam int OSEL_W = 6;
	localparam int CNT_W = 16;
	localparam int NUM_TERM = 5;
	localparam int FAST_IDX = 4;
	localparam int NUM_EVT = 3;

	// Register indices
	localparam logic [ADDR_W-1:0] REG_FAST_TYPE = 4'h0;
	localparam logic [ADDR_W-1:0] REG_IN_ONE_FUNC = 4'h1;
	localparam logic [ADDR_W-1:0] REG_IN_TWO_FUNC = 4'h2;
	localparam logic [ADDR_W-1:0] REG_IN_THREE_FUNC = 4'h3;
	localparam logic [ADDR_W-1:0] REG_IN_FOUR_FUNC = 4'h4;
	localparam logic [ADDR_W-1:0] REG_FAST_FUNC = 4'h5;
	localparam logic [ADDR_W-1:0] REG_TRANS_SEL = 4'h6;
	localparam logic [ADDR_W-1:0] REG_RELAY_ONE_SEL = 4'h7;
	localparam logic [ADDR_W-1:0] REG_RELAY_TWO_SEL = 4'h8;
	localparam logic [ADDR_W-1:0] REG_SET_VALUE = 4'h9;
	localparam logic [ADDR_W-1:0] REG_DESIG_VALUE = 4'hA;
	localparam logic [ADDR_W-1:0] REG_ACCUM = 4'hB;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'hC;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hD;

	// Function and output selection codes
	localparam logic [FUNC_W-1:0] FUNC_COUNT_RESET = 7'h1C;
	localparam logic [FUNC_W-1:0] FUNC_COUNT_TRIGGER = 7'h1F;
	localparam logic [OSEL_W-1:0] OSEL_SET_REACHED = 6'h12;
	localparam logic [OSEL_W-1:0] OSEL_DESIG_REACHED = 6'h13;

	// High-speed terminal type
	localparam logic FAST_TYPE_PULSE = 1'b0;
	localparam logic FAST_TYPE_DIGITAL = 1'b1;

	// Reset values
	localparam logic RST_FAST_TYPE = 1'b0;
	localparam logic [FUNC_W-1:0] RST_IN_ONE_FUNC = 7'h01;
	localparam logic [FUNC_W-1:0] RST_IN_TWO_FUNC = 7'h04;
	localparam logic [FUNC_W-1:0] RST_IN_THREE_FUNC = 7'h07;
	localparam logic [FUNC_W-1:0] RST_IN_FOUR_FUNC = 7'h00;
	localparam logic [FUNC_W-1:0] RST_FAST_FUNC = 7'h00;
	localparam logic [OSEL_W-1:0] RST_TRANS_SEL = 6'h00;
	localparam logic [OSEL_W-1:0] RST_RELAY_ONE_SEL = 6'h01;
	localparam logic [OSEL_W-1:0] RST_RELAY_TWO_SEL = 6'h05;
	localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// Interrupt status bit positions
	localparam int EVT_SET_REACHED = 0;
	localparam int EVT_DESIG_REACHED = 1;
	localparam int EVT_CLEARED = 2;
endpackage
`default_nettype wire

// ---- verilog/terminal_sync.sv ----
// Three-stage synchroniser with agreement filter for terminal inputs
`timescale 1ns/1ps
`default_nettype none
module terminal_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Raw pins and filtered levels
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_level
);
	logic [WIDTH-1:0] stage_one_ff;
	logic [WIDTH-1:0] stage_two_ff;
	logic [WIDTH-1:0] stage_three_ff;
	logic [WIDTH-1:0] level_ff;
	logic [WIDTH-1:0] nxt_level;

	// Only stages two and three are compared; stage one may be metastable
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_level[i] = (stage_two_ff[i] == stage_three_ff[i]) ? stage_three_ff[i] : level_ff[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage_one_ff <= '0;
			stage_two_ff <= '0;
			stage_three_ff <= '0;
			level_ff <= '0;
		end else begin
			stage_one_ff <= pin_raw;
			stage_two_ff <= stage_one_ff;
			stage_three_ff <= stage_two_ff;
			level_ff <= nxt_level;
		end
	end

	assign pin_level = level_ff;
endmodule
`default_nettype wire
